/* include/dsihoc_pkg.sv */
// constants, register map and types of the operation control block
`default_nettype none

package dsihoc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [ADDR_W-1:0] OFF_OPCTL     = 8'hc0;
    localparam logic [ADDR_W-1:0] OFF_MRS       = 8'hc1;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT  = 8'he0;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 8'he1;
    localparam logic [ADDR_W-1:0] OFF_TXDATA    = 8'he2;
    localparam logic [ADDR_W-1:0] OFF_CMD       = 8'he3;

    // operation_control fields
    localparam int BIT_CANCEL = 0;
    localparam int BIT_SRST   = 8;

    // command register fields
    localparam int CMD_WRITE   = 0;
    localparam int CMD_READ    = 1;
    localparam int CMD_BUSY    = 4;
    localparam int CMD_CNT_LSB = 8;
    localparam int CMD_CNT_W   = 8;

    // reset values
    localparam logic [DATA_W-1:0] MRS_RESET  = 16'h0001;
    localparam logic [DATA_W-1:0] MASK_RESET = 16'h0000;

    // interrupt events
    localparam int N_EVT    = 4;
    localparam int EVT_DONE = 0;
    localparam int EVT_SRST = 1;
    localparam int EVT_SMRS = 2;
    localparam int EVT_OVF  = 3;

    // timing
    localparam int CLK_NS      = 25;
    localparam int SRST_NS     = 100;
    localparam int SRST_CYCLES = (SRST_NS + CLK_NS - 1) / CLK_NS;

    // packet header word: type in the high byte, payload words in the low
    localparam int HDR_LEN_W = 8;
    localparam logic [7:0] PT_SMRS  = 8'h37;
    localparam logic [7:0] PT_WRITE = 8'h39;
    localparam logic [7:0] PT_READ  = 8'h06;
    localparam logic [HDR_LEN_W-1:0] SMRS_LEN = 8'h01;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_SMRS_HDR,
        TX_SMRS_VAL,
        TX_HDR,
        TX_FETCH,
        TX_LOAD,
        TX_PAY
    } dsihoc_tx_e;

endpackage : dsihoc_pkg

`default_nettype wire

/* include/dsihoc_buf_if.sv */
// transmit buffer connection between control logic and its memory
`default_nettype none

interface dsihoc_buf_if #(
    parameter int W  = 16,
    parameter int CW = 5
);
    logic          wr_en;
    logic [W-1:0]  wr_data;
    logic          rd_en;
    logic [W-1:0]  rd_data;
    logic          flush;
    logic [CW-1:0] count;
    logic          full;
    logic          empty;

    modport mem (
        input  wr_en,
        input  wr_data,
        input  rd_en,
        input  flush,
        output rd_data,
        output count,
        output full,
        output empty
    );

    modport ctl (
        output wr_en,
        output wr_data,
        output rd_en,
        output flush,
        input  rd_data,
        input  count,
        input  full,
        input  empty
    );
endinterface : dsihoc_buf_if

`default_nettype wire

/* design/dsihoc_txbuf.sv */
// transmit buffer memory with registered read data and flush
`default_nettype none

module dsihoc_txbuf #(
    parameter int W     = 16,
    parameter int DEPTH = 16
) (
    input wire logic    sys_clk,
    input wire logic    reset,
    dsihoc_buf_if.mem   bus
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
            $error("dsihoc_txbuf: DEPTH must be a power of two >= 2");
        end
    endgenerate

    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic [W-1:0]  rd_r;

    wire do_wr = bus.wr_en && (cnt_r != CNT_FULL) && !bus.flush;
    wire do_rd = bus.rd_en && (cnt_r != '0) && !bus.flush;

    always_ff @(posedge sys_clk) begin
        if (do_wr) begin
            mem_r[wp_r] <= bus.wr_data;
        end
    end

    // flush drops unsent words by resetting the pointers and the count only
    always_ff @(posedge sys_clk) begin
        if (reset || bus.flush) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (do_wr) begin
                wp_r <= wp_r + 1'b1;
            end
            if (do_rd) begin
                rp_r <= rp_r + 1'b1;
            end
            if (do_wr && !do_rd) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (do_rd && !do_wr) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rd_r <= '0;
        end else if (do_rd) begin
            rd_r <= mem_r[rp_r];
        end
    end

    assign bus.rd_data = rd_r;
    assign bus.count   = cnt_r;
    assign bus.full    = (cnt_r == CNT_FULL);
    assign bus.empty   = (cnt_r == '0);

endmodule : dsihoc_txbuf

`default_nettype wire

/* design/dsihoc_top.sv */
// operation control, soft reset, cancel and return size packet logic
//
// What this block does
// R1 - soft reset clears logic, keeps register settings
// R2 - soft reset bit clears itself when done
// R3 - soft reset stops link, aborts packet instantly
// R4 - cancel finishes current packet, then stops
// R5 - cancel discards unsent transmit buffer data
// R6 - cancel returns transmit machine to idle
// R7 - cancel bit clears itself when finished
// R8 - done flag sets as cancel bit clears
// R9 - software avoids cancel while video enabled
// R10 - sixteen bit read/write maximum return size
// R11 - return size packet precedes every read
// R12 - return size packet sent even if unchanged
// R13 - zero writes ignored, other bits read zero
`default_nettype none

module dsihoc_top
    import dsihoc_pkg::*;
#(
    parameter int BUF_DEPTH = 16,
    parameter int SRST_LEN  = SRST_CYCLES
) (
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output var  logic [DATA_W-1:0] reg_rdata,
    input  wire logic              video_enable,
    output var  logic              tx_valid,
    input  wire logic              tx_ready,
    output var  logic [DATA_W-1:0] tx_data,
    output var  logic              tx_first,
    output var  logic              tx_last,
    output var  logic              link_stop,
    output var  logic              irq
);
    localparam int CNT_W = $clog2(BUF_DEPTH) + 1;
    localparam int SC_W  = (SRST_LEN > 1) ? $clog2(SRST_LEN) : 1;
    localparam logic [SC_W-1:0] SRST_LAST = SC_W'(SRST_LEN - 1);

    generate
        if (BUF_DEPTH < 2 || BUF_DEPTH > 128) begin : g_chk_depth
            $error("dsihoc_top: BUF_DEPTH must lie in 2..128");
        end
        if (SRST_LEN < 1) begin : g_chk_srst
            $error("dsihoc_top: SRST_LEN must be at least 1");
        end
    endgenerate

    function automatic logic hit(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] off
    );
        return a == off;
    endfunction : hit

    dsihoc_buf_if #(.W(DATA_W), .CW(CNT_W)) txq ();

    dsihoc_txbuf #(
        .W     (DATA_W),
        .DEPTH (BUF_DEPTH)
    ) u_txbuf (
        .sys_clk (sys_clk),
        .reset   (reset),
        .bus     (txq)
    );

    logic              soft_rst_r;
    logic [SC_W-1:0]   srst_cnt_r;
    logic              cancel_r;
    logic [DATA_W-1:0] mrs_r;
    logic [DATA_W-1:0] mask_r;
    logic [N_EVT-1:0]  stat_r;
    logic              pend_wr_r;
    logic              pend_rd_r;
    dsihoc_tx_e        state_r;
    logic              valid_r;
    logic [DATA_W-1:0] data_r;
    logic              first_r;
    logic              last_r;
    logic [CNT_W-1:0]  len_r;
    logic [CNT_W-1:0]  left_r;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rd_mux;
    logic [N_EVT-1:0]  evt;

    logic wr_opctl;
    logic srst_req;
    logic srst_done;
    logic cancel_req;
    logic cancel_done;
    logic int_rst;
    logic beat;

    assign wr_opctl = reg_wr && hit(reg_addr, OFF_OPCTL);

    // R13 only a one acts
    assign srst_req = wr_opctl && reg_wdata[BIT_SRST];
    // R9 cancel refused in video mode
    assign cancel_req = wr_opctl && reg_wdata[BIT_CANCEL] && !video_enable;

    assign srst_done = soft_rst_r && (srst_cnt_r == SRST_LAST);
    // R1 soft reset internal logic
    assign int_rst   = reset || soft_rst_r;
    assign beat      = tx_valid && tx_ready;

    // R6 done only from idle
    assign cancel_done = cancel_r && (state_r == TX_IDLE) && !soft_rst_r;

    // soft reset sequencer: holds the internal reset for SRST_LEN cycles
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            soft_rst_r <= 1'b0;
            srst_cnt_r <= '0;
        end else if (!soft_rst_r) begin
            srst_cnt_r <= '0;
            if (srst_req) begin
                soft_rst_r <= 1'b1;
            end
        // R2 self clearing bit
        end else if (srst_done) begin
            soft_rst_r <= 1'b0;
        end else begin
            srst_cnt_r <= srst_cnt_r + 1'b1;
        end
    end

    // cancel bit; a soft reset abandons a pending cancel
    always_ff @(posedge sys_clk) begin
        if (int_rst) begin
            cancel_r <= 1'b0;
        // R7 self clearing cancel
        end else if (cancel_done) begin
            cancel_r <= 1'b0;
        end else if (cancel_req) begin
            cancel_r <= 1'b1;
        end
    end

    // settings survive soft reset, only the hard reset clears them
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mrs_r <= MRS_RESET;
        // R10 return size field
        end else if (reg_wr && hit(reg_addr, OFF_MRS)) begin
            mrs_r <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mask_r <= MASK_RESET;
        end else if (reg_wr && hit(reg_addr, OFF_IRQ_MASK)) begin
            mask_r <= reg_wdata;
        end
    end

    // R8 done flag event
    assign evt[EVT_DONE] = cancel_done;
    assign evt[EVT_SRST] = srst_done;
    assign evt[EVT_SMRS] = beat && (state_r == TX_SMRS_VAL);
    assign evt[EVT_OVF]  = reg_wr && hit(reg_addr, OFF_TXDATA) && txq.full;

    // sticky status, a new event wins over a write-one clear
    genvar gi;
    generate
        for (gi = 0; gi < N_EVT; gi++) begin : g_stat
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    stat_r[gi] <= 1'b0;
                end else if (evt[gi]) begin
                    stat_r[gi] <= 1'b1;
                end else if (reg_wr && hit(reg_addr, OFF_IRQ_STAT)
                             && reg_wdata[gi]) begin
                    stat_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign irq = |(stat_r & mask_r[N_EVT-1:0]);

    // one command held at a time; a second one while pending is dropped
    always_ff @(posedge sys_clk) begin
        if (int_rst || cancel_done) begin
            pend_wr_r <= 1'b0;
            pend_rd_r <= 1'b0;
        end else if (state_r == TX_IDLE && !cancel_r
                     && (pend_wr_r || pend_rd_r)) begin
            pend_wr_r <= 1'b0;
            pend_rd_r <= 1'b0;
        end else if (reg_wr && hit(reg_addr, OFF_CMD)
                     && !pend_wr_r && !pend_rd_r) begin
            pend_rd_r <= reg_wdata[CMD_READ];
            pend_wr_r <= reg_wdata[CMD_WRITE] && !reg_wdata[CMD_READ];
        end
    end

    // transmit machine; data words come one per three cycles at best
    always_ff @(posedge sys_clk) begin
        if (int_rst) begin
            state_r <= TX_IDLE;
            valid_r <= 1'b0;
            data_r  <= '0;
            first_r <= 1'b0;
            last_r  <= 1'b0;
            len_r   <= '0;
            left_r  <= '0;
        end else begin
            unique case (state_r)
                TX_IDLE: begin
                    // R4 no new start while cancelling
                    if ((pend_wr_r || pend_rd_r) && !cancel_r) begin
                        len_r   <= txq.count;
                        left_r  <= txq.count;
                        valid_r <= 1'b1;
                        first_r <= 1'b1;
                        if (pend_rd_r) begin
                            // R11 return size packet first
                            state_r <= TX_SMRS_HDR;
                            data_r  <= {PT_SMRS, SMRS_LEN};
                            last_r  <= 1'b0;
                        end else begin
                            state_r <= TX_HDR;
                            data_r  <= {PT_WRITE,
                                        HDR_LEN_W'(txq.count)};
                            last_r  <= (txq.count == '0);
                        end
                    end
                end
                TX_SMRS_HDR: begin
                    if (beat) begin
                        state_r <= TX_SMRS_VAL;
                        // R12 value sent on every read
                        data_r  <= mrs_r;
                        first_r <= 1'b0;
                        last_r  <= 1'b1;
                    end
                end
                TX_SMRS_VAL: begin
                    if (beat) begin
                        // R4 stop after finished packet
                        if (cancel_r) begin
                            state_r <= TX_IDLE;
                            valid_r <= 1'b0;
                            last_r  <= 1'b0;
                        end else begin
                            state_r <= TX_HDR;
                            data_r  <= {PT_READ, HDR_LEN_W'(len_r)};
                            first_r <= 1'b1;
                            last_r  <= (len_r == '0);
                        end
                    end
                end
                TX_HDR: begin
                    if (beat) begin
                        valid_r <= 1'b0;
                        first_r <= 1'b0;
                        state_r <= last_r ? TX_IDLE : TX_FETCH;
                    end
                end
                TX_FETCH: begin
                    left_r  <= left_r - 1'b1;
                    state_r <= TX_LOAD;
                end
                TX_LOAD: begin
                    data_r  <= txq.rd_data;
                    last_r  <= (left_r == '0);
                    valid_r <= 1'b1;
                    state_r <= TX_PAY;
                end
                TX_PAY: begin
                    // R4 packet runs to its end
                    if (beat) begin
                        valid_r <= 1'b0;
                        state_r <= last_r ? TX_IDLE : TX_FETCH;
                    end
                end
                default: begin
                    state_r <= TX_IDLE;
                    valid_r <= 1'b0;
                end
            endcase
        end
    end

    // buffer fill ignored during soft reset so nothing stale survives
    assign txq.wr_en   = reg_wr && hit(reg_addr, OFF_TXDATA) && !soft_rst_r;
    assign txq.wr_data = reg_wdata;
    assign txq.rd_en   = (state_r == TX_FETCH);
    // R5 flush unsent words
    assign txq.flush   = cancel_done || soft_rst_r;

    // R3 stop link now
    assign tx_valid  = valid_r && !soft_rst_r && !srst_req;
    assign link_stop = soft_rst_r || srst_req || (state_r == TX_IDLE);
    assign tx_data   = data_r;
    assign tx_first  = first_r;
    assign tx_last   = last_r;

    always_comb begin
        rd_mux = '0;
        unique case (1'b1)
            // R13 reserved bits zero
            hit(reg_addr, OFF_OPCTL): begin
                rd_mux[BIT_SRST]   = soft_rst_r;
                rd_mux[BIT_CANCEL] = cancel_r;
            end
            hit(reg_addr, OFF_MRS): begin
                rd_mux = mrs_r;
            end
            hit(reg_addr, OFF_IRQ_STAT): begin
                rd_mux[N_EVT-1:0] = stat_r;
            end
            hit(reg_addr, OFF_IRQ_MASK): begin
                rd_mux = mask_r;
            end
            hit(reg_addr, OFF_CMD): begin
                rd_mux[CMD_WRITE] = pend_wr_r;
                rd_mux[CMD_READ]  = pend_rd_r;
                rd_mux[CMD_BUSY]  = (state_r != TX_IDLE);
                rd_mux[CMD_CNT_LSB +: CMD_CNT_W] = CMD_CNT_W'(txq.count);
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_r <= '0;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= '0;
        end
    end

    assign reg_rdata = rdata_r;

endmodule : dsihoc_top

`default_nettype wire

/* verification/dsihoc_top_properties.sv */
// assertion checker for the operation control block
`default_nettype none

module dsihoc_top_chk
    import dsihoc_pkg::*;
#(
    parameter int BUF_DEPTH = 16,
    parameter int SRST_LEN  = SRST_CYCLES
) (
    input wire logic              sys_clk,
    input wire logic              reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              video_enable,
    input wire logic              tx_valid,
    input wire logic              tx_ready,
    input wire logic [DATA_W-1:0] tx_data,
    input wire logic              tx_first,
    input wire logic              tx_last,
    input wire logic              link_stop,
    input wire logic              irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    logic              srst_wr;
    logic              take;
    logic              hdr_r;
    logic              seen_r;
    logic [DATA_W-1:0] mrs_r;
    assign srst_wr = reg_wr && reg_addr == OFF_OPCTL && reg_wdata[BIT_SRST];
    assign take    = tx_valid && tx_ready;

    // shadow of the size setting; soft reset must not touch it
    always_ff @(posedge sys_clk) begin
        if (reset) mrs_r <= MRS_RESET;
        else if (reg_wr && reg_addr == OFF_MRS) mrs_r <= reg_wdata;
    end
    // hdr_r: size header just taken; seen_r: last packet was size packet
    always_ff @(posedge sys_clk) begin
        if (reset || srst_wr) hdr_r <= 1'b0;
        else if (take) hdr_r <= tx_first && tx_data == {PT_SMRS, SMRS_LEN};
    end
    always_ff @(posedge sys_clk) begin
        if (reset) seen_r <= 1'b0;
        else if (take && tx_first) seen_r <= tx_data == {PT_SMRS, SMRS_LEN};
    end

    chk_srst_stop: assert property (srst_wr |-> link_stop && !tx_valid)
        else $error("link not stopped in soft reset write");
    chk_srst_hold: assert property (srst_wr |=>
        (link_stop && !tx_valid) [*3])
        else $error("link active during soft reset");
    chk_word_stands: assert property (tx_valid && !tx_ready |=>
        srst_wr || (tx_valid && $stable(tx_data) && $stable(tx_last)))
        else $error("link word changed before acceptance");
    chk_smrs_value: assert property (take && hdr_r |->
        tx_data == mrs_r && tx_last && !tx_first)
        else $error("size packet value wrong");
    chk_smrs_wait: assert property (@(posedge sys_clk)
        disable iff (reset || srst_wr) $rose(hdr_r) |-> ##[0:60] take)
        else $error("size packet value never sent");
    chk_read_first: assert property (tx_valid && tx_first &&
        tx_data[15:8] == PT_READ |-> seen_r)
        else $error("read packet without size packet");
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data outside read cycle");
    chk_mrs_read: assert property (reg_rd && reg_addr == OFF_MRS |=>
        reg_rdata == mrs_r)
        else $error("size setting read back wrong");
    chk_opctl_zero: assert property (reg_rd && reg_addr == OFF_OPCTL |=>
        reg_rdata[15:9] == 7'h00 && reg_rdata[7:1] == 7'h00)
        else $error("reserved control bits not zero");
    chk_valid_stop: assert property (tx_valid |-> !link_stop)
        else $error("word offered while link stopped");

    cov_srst: cover property (srst_wr);
    cov_read: cover property (take && tx_first && tx_data[15:8] == PT_READ);
    cov_cancel: cover property (reg_wr && reg_addr == OFF_OPCTL &&
        reg_wdata[BIT_CANCEL] && tx_valid);
    cov_irq: cover property (irq);
endmodule : dsihoc_top_chk

bind dsihoc_top dsihoc_top_chk #(.BUF_DEPTH(BUF_DEPTH), .SRST_LEN(SRST_LEN))
    u_chk (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .video_enable(video_enable),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_first(tx_first), .tx_last(tx_last), .link_stop(link_stop),
    .irq(irq));

`default_nettype wire

/* verification/dsihoc_sink.sv */
// link sink model: prompt, randomly stalling or fully stalled
`default_nettype none

module dsihoc_sink
    import dsihoc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic [1:0]        mode,
    input  wire logic              tx_valid,
    input  wire logic [DATA_W-1:0] tx_data,
    output var  logic              tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] got[$];
    logic [15:0]       lf = 16'hc0d1;
    // mode 0 prompt, 1 random stalls, 2 stalled
    always @(posedge sys_clk) begin
        lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        if (!reset && tx_valid && tx_ready) got.push_back(tx_data);
        tx_ready <= !reset && (mode == 2'd0 || (mode == 2'd1 && lf[0]));
    end
endmodule : dsihoc_sink

`default_nettype wire

/* verification/tb_dsi_host_operation_control.sv */
// self-checking bench for the operation control block
`default_nettype none

`define CHECK(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            $display("[FAIL] %s exp %h got %h", what, exp, got); \
            bad_count++; \
        end \
    end

module tb_dsi_host_operation_control;
    timeunit 1ns;
    timeprecision 1ps;
    import dsihoc_pkg::*;
    logic              sys_clk = 1'b0;
    logic              reset = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic              video_enable = 1'b0;
    logic [1:0]        mode = 2'd0;
    logic [DATA_W-1:0] reg_rdata, tx_data, v, max_return_size;
    logic              tx_valid, tx_ready, tx_first, tx_last, link_stop, irq;
    logic [31:0]       rnd = 32'hc0d1;
    logic [DATA_W-1:0] exp_q[$];
    int                bad_count = 0;
    int                tests_run = 0;

    always #12.5 sys_clk = ~sys_clk;

    dsihoc_top uut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .video_enable(video_enable),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .tx_first(tx_first), .tx_last(tx_last), .link_stop(link_stop),
        .irq(irq));
    dsihoc_sink sink (.sys_clk(sys_clk), .reset(reset), .mode(mode),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [15:0] hdr(input logic [7:0] t, input int n);
        return {t, 8'(n)};
    endfunction : hdr

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic push(input int n, input bit keep);
        for (int i = 0; i < n; i++) begin
            rnd = lfsr(rnd);
            wr(OFF_TXDATA, rnd[15:0]);
            if (keep) exp_q.push_back(rnd[15:0]);
        end
    endtask : push
    task automatic wait_idle();
        logic [15:0] s;
        for (int i = 0; i < 200; i++) begin
            rd(OFF_CMD, s);
            if (s[CMD_BUSY] === 1'b0 && s[1:0] === 2'b00) return;
        end
        bad_count++;
        wrap_up();
    endtask : wait_idle
    task automatic cmp_pkt(input string what);
        logic [15:0] e;
        logic [15:0] g;
        `CHECK(what, exp_q.size(), sink.got.size())
        while (exp_q.size() > 0 && sink.got.size() > 0) begin
            e = exp_q.pop_front();
            g = sink.got.pop_front();
            `CHECK(what, e, g)
        end
        exp_q.delete();
        sink.got.delete();
    endtask : cmp_pkt
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        rd(OFF_MRS, v);
        `CHECK("mrs reset", MRS_RESET, v)
        wr(OFF_OPCTL, 16'hfeee);
        rd(OFF_OPCTL, v);
        `CHECK("opctl zero write", 16'h0000, v)
        rd(8'h10, v);
        `CHECK("unmapped read", 16'h0000, v)
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            max_return_size = (i == 0) ? 16'hffff : rnd[15:0];
            wr(OFF_MRS, max_return_size);
            rd(OFF_MRS, v);
            `CHECK("mrs rw", max_return_size, v)
        end
        mode <= 2'd1;
        for (int n = 1; n < 4; n++) begin
            exp_q.push_back(hdr(PT_WRITE, n));
            push(n, 1'b1);
            wr(OFF_CMD, 16'h0001);
            wait_idle();
            cmp_pkt("write pkt");
        end
        // same size twice: the size packet must still go out
        for (int k = 0; k < 2; k++) begin
            exp_q.push_back(hdr(PT_SMRS, 1));
            exp_q.push_back(max_return_size);
            exp_q.push_back(hdr(PT_READ, 1));
            push(1, 1'b1);
            wr(OFF_CMD, 16'h0002);
            wait_idle();
            cmp_pkt("read pkt");
        end
        wr(OFF_IRQ_MASK, 16'h0004);
        `CHECK("irq unmasked", 1'b1, irq)
        wr(OFF_IRQ_MASK, 16'h0000);
        `CHECK("irq masked", 1'b0, irq)
        wr(OFF_IRQ_MASK, 16'h0004);
        wr(OFF_IRQ_STAT, 16'hffff);
        `CHECK("irq cleared", 1'b0, irq)
        // cancel with a stalled packet and unsent data behind it
        mode <= 2'd2;
        exp_q.push_back(hdr(PT_WRITE, 2));
        push(2, 1'b1);
        wr(OFF_CMD, 16'h0001);
        push(3, 1'b0);
        wr(OFF_CMD, 16'h0001);
        wr(OFF_OPCTL, 16'h0001);
        rd(OFF_OPCTL, v);
        `CHECK("cancel pending", 16'h0001, v)
        mode <= 2'd0;
        for (int i = 0; i < 40 && v[BIT_CANCEL] !== 1'b0; i++)
            rd(OFF_OPCTL, v);
        `CHECK("cancel clear", 1'b0, v[BIT_CANCEL])
        rd(OFF_IRQ_STAT, v);
        `CHECK("done flag", 1'b1, v[EVT_DONE])
        rd(OFF_CMD, v);
        `CHECK("buffer flushed", 8'h00, v[15:8])
        `CHECK("machine idle", 1'b0, v[CMD_BUSY])
        cmp_pkt("cancel pkt");
        @(posedge sys_clk) video_enable <= 1'b1;
        wr(OFF_OPCTL, 16'h0001);
        rd(OFF_OPCTL, v);
        `CHECK("cancel in video", 16'h0000, v)
        @(posedge sys_clk) video_enable <= 1'b0;
        // soft reset in the middle of an offered packet
        wr(OFF_IRQ_STAT, 16'hffff);
        mode <= 2'd2;
        push(2, 1'b0);
        wr(OFF_CMD, 16'h0001);
        for (int i = 0; i < 20 && tx_valid !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        `CHECK("packet offered", 1'b1, tx_valid)
        wr(OFF_OPCTL, 16'h0100);
        mode <= 2'd0;
        rd(OFF_OPCTL, v);
        `CHECK("srst busy", 1'b1, v[BIT_SRST])
        for (int i = 0; i < 8 && v[BIT_SRST] === 1'b1; i++)
            rd(OFF_OPCTL, v);
        `CHECK("srst clear", 1'b0, v[BIT_SRST])
        rd(OFF_MRS, v);
        `CHECK("mrs kept", max_return_size, v)
        rd(OFF_IRQ_MASK, v);
        `CHECK("mask kept", 16'h0004, v)
        rd(OFF_CMD, v);
        `CHECK("logic cleared", 16'h0000, v)
        rd(OFF_IRQ_STAT, v);
        `CHECK("srst event", 16'h0002, v)
        repeat (10) @(posedge sys_clk);
        `CHECK("packet aborted", 0, sink.got.size())
        wrap_up();
    end
endmodule : tb_dsi_host_operation_control

`default_nettype wire
